// >>> hw/scf_pkg.sv
// package: constants, types and field layout of the system clock select and failover block
package scf_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // bus
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam logic [11:0] CTRL_ADDR = 12'h0f86;
    localparam logic [11:0] STAT_ADDR = 12'h0f87;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } scf_bus_req_t;

    ////////////////////////////////////////////////////////////////////////////
    // control register layout
    localparam logic [7:0] CTRL_RESET = 8'ha0;
    localparam int PRC_ON_BIT = 7;
    localparam int RSVD_BIT = 6;
    localparam int WRC_ON_BIT = 5;
    localparam int PFD_ON_BIT = 4;
    localparam int WFD_ON_BIT = 3;
    localparam int SRC_LSB = 0;
    localparam int SRC_W = 3;
    localparam logic [7:0] UNLOCK_FIRST = 8'he7;
    localparam logic [7:0] UNLOCK_SECOND = 8'h18;

    typedef enum logic [2:0] {
        SRC_PRC_FAST = 3'b000,
        SRC_PRC_SLOW = 3'b001,
        SRC_WRC = 3'b011,
        SRC_PIN = 3'b100
    } scf_src_t;

    // status register layout
    localparam int ST_UNLOCKED_BIT = 0;
    localparam int ST_FIRST_BIT = 1;
    localparam int ST_PFAIL_BIT = 2;
    localparam int ST_WFAIL_BIT = 3;

    typedef enum logic [1:0] {
        LK_LOCKED = 2'b00,
        LK_FIRST = 2'b01,
        LK_OPEN = 2'b10
    } scf_lock_t;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CORE_CLK_HZ = 25000000;
    localparam int WRC_NOMINAL_HZ = 10000;
    localparam int PRIMARY_FAIL_HZ = 1000;
    localparam int PRIMARY_FAIL_TICKS = WRC_NOMINAL_HZ / PRIMARY_FAIL_HZ;
    localparam int WRC_FAIL_SYSCLKS = 8004;
    localparam int CNT_W = 14;
    localparam int PIN_N = 3;
    localparam int PIN_WRC = 0;
    localparam int PIN_PRC = 1;
    localparam int PIN_EXT = 2;

endpackage : scf_pkg

// >>> hw/scf_miss_counter.sv
// counts ticks while waiting for an awaited edge; one pulse when the limit is reached
`timescale 1ns/100ps
module scf_miss_counter #(
    parameter int unsigned LIMIT = 8004
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // events
    input wire logic enable_in,
    input wire logic tick_in,
    input wire logic seen_in,
    // result
    output logic fail_out
);

    logic [scf_pkg::CNT_W-1:0] count_r;
    logic [scf_pkg::CNT_W-1:0] count_nxt;
    logic tripped_r;
    logic tripped_nxt;
    logic fail_nxt;
    wire logic at_limit;

    assign at_limit = (count_r == scf_pkg::CNT_W'(LIMIT - 1));

    // an awaited edge restarts the count; one pulse per miss until the edge returns
    always_comb
    begin
        count_nxt = count_r;
        tripped_nxt = tripped_r;
        fail_nxt = 1'b0;
        if (!enable_in || seen_in)
        begin
            count_nxt = '0;
            tripped_nxt = 1'b0;
        end
        else if (tick_in && !tripped_r)
        begin
            if (at_limit)
            begin
                fail_nxt = 1'b1;
                tripped_nxt = 1'b1;
                count_nxt = '0;
            end
            else
            begin
                count_nxt = count_r + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            count_r <= '0;
            tripped_r <= 1'b0;
            fail_out <= 1'b0;
        end
        else
        begin
            count_r <= count_nxt;
            tripped_r <= tripped_nxt;
            fail_out <= fail_nxt;
        end
    end

endmodule : scf_miss_counter

// >>> hw/scf_clock_control.sv
// top: clock source control register, unlock sequence and clock failure supervision
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
module scf_clock_control #(
    parameter int unsigned WRC_FAIL_COUNT = scf_pkg::WRC_FAIL_SYSCLKS
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // register port
    input wire scf_pkg::scf_bus_req_t bus_req_in,
    output logic [7:0] bus_rdata_out,
    // oscillator activity pins
    input wire logic watchdog_rc_clk_in,
    input wire logic precision_rc_clk_in,
    input wire logic external_clock_pin_in,
    // oscillator control
    output logic precision_rc_on_out,
    output logic precision_rc_fast_out,
    output logic watchdog_rc_on_out,
    output logic [2:0] sys_clock_source_out,
    // failure events
    output logic primary_fail_event_out,
    output logic watchdog_rc_fail_event_out
);

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic src_is_wrc(input logic [2:0] src);
        src_is_wrc = (src == scf_pkg::SRC_WRC);
    endfunction : src_is_wrc

    function automatic logic src_is_prc(input logic [2:0] src);
        src_is_prc = (src == scf_pkg::SRC_PRC_FAST) || (src == scf_pkg::SRC_PRC_SLOW);
    endfunction : src_is_prc

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detect

    wire logic [scf_pkg::PIN_N-1:0] pin_raw;
    logic [scf_pkg::PIN_N-1:0] pin_meta_r;
    logic [scf_pkg::PIN_N-1:0] pin_sync_r;
    logic [scf_pkg::PIN_N-1:0] pin_last_r;
    wire logic [scf_pkg::PIN_N-1:0] pin_rise;

    assign pin_raw[scf_pkg::PIN_WRC] = watchdog_rc_clk_in;
    assign pin_raw[scf_pkg::PIN_PRC] = precision_rc_clk_in;
    assign pin_raw[scf_pkg::PIN_EXT] = external_clock_pin_in;

    // oscillator edges faster than half the core clock alias; only slow activity is judged
    genvar gi;
    generate
        for (gi = 0; gi < scf_pkg::PIN_N; gi++)
        begin : g_pin
            always_ff @(posedge core_clk_in or posedge rst_in)
            begin
                if (rst_in)
                begin
                    pin_meta_r[gi] <= 1'b0;
                    pin_sync_r[gi] <= 1'b0;
                    pin_last_r[gi] <= 1'b0;
                end
                else
                begin
                    pin_meta_r[gi] <= pin_raw[gi];
                    pin_sync_r[gi] <= pin_meta_r[gi];
                    pin_last_r[gi] <= pin_sync_r[gi];
                end
            end
            assign pin_rise[gi] = pin_sync_r[gi] & ~pin_last_r[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // register state

    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    scf_pkg::scf_lock_t lock_r;
    scf_pkg::scf_lock_t lock_nxt;
    logic pfail_seen_r;
    logic pfail_seen_nxt;
    logic wfail_seen_r;
    logic wfail_seen_nxt;
    logic [7:0] rdata_nxt;

    wire logic [2:0] cur_src;
    wire logic prc_on;
    wire logic wrc_on;
    wire logic pfd_on;
    wire logic wfd_on;

    assign cur_src = ctrl_r[scf_pkg::SRC_LSB +: scf_pkg::SRC_W];
    assign prc_on = ctrl_r[scf_pkg::PRC_ON_BIT];
    assign wrc_on = ctrl_r[scf_pkg::WRC_ON_BIT];
    assign pfd_on = ctrl_r[scf_pkg::PFD_ON_BIT];
    assign wfd_on = ctrl_r[scf_pkg::WFD_ON_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    wire logic hit_ctrl;
    wire logic hit_stat;
    wire logic ctrl_wr;
    wire logic ctrl_commit;

    assign hit_ctrl = (bus_req_in.addr == scf_pkg::CTRL_ADDR);
    assign hit_stat = (bus_req_in.addr == scf_pkg::STAT_ADDR);
    assign ctrl_wr = bus_req_in.wr && hit_ctrl;
    assign ctrl_commit = ctrl_wr && (lock_r == scf_pkg::LK_OPEN);

    ////////////////////////////////////////////////////////////////////////////
    // unlock sequence

    always_comb
    begin
        lock_nxt = lock_r;
        if (ctrl_wr)
        begin
            case (lock_r)
                scf_pkg::LK_LOCKED:
                begin
                    if (bus_req_in.wdata == scf_pkg::UNLOCK_FIRST)
                    begin
                        lock_nxt = scf_pkg::LK_FIRST;
                    end
                end
                scf_pkg::LK_FIRST:
                begin
                    if (bus_req_in.wdata == scf_pkg::UNLOCK_SECOND)
                    begin
                        lock_nxt = scf_pkg::LK_OPEN;
                    end
                    else if (bus_req_in.wdata == scf_pkg::UNLOCK_FIRST)
                    begin
                        lock_nxt = scf_pkg::LK_FIRST;
                    end
                    else
                    begin
                        lock_nxt = scf_pkg::LK_LOCKED;
                    end
                end
                scf_pkg::LK_OPEN:
                begin
                    lock_nxt = scf_pkg::LK_LOCKED;
                end
                default:
                begin
                    lock_nxt = scf_pkg::LK_LOCKED;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // failure supervision

    wire logic sel_edge;
    wire logic pfd_active;
    wire logic wfd_active;
    wire logic pfail_hit;
    wire logic wfail_hit;
    wire logic fallback;

    // edges of whichever oscillator is driving the system clock now
    assign sel_edge = src_is_prc(cur_src) ? pin_rise[scf_pkg::PIN_PRC] :
                      src_is_wrc(cur_src) ? pin_rise[scf_pkg::PIN_WRC] :
                      (cur_src == scf_pkg::SRC_PIN) ? pin_rise[scf_pkg::PIN_EXT] : 1'b0;

    assign pfd_active = pfd_on && wrc_on && !wfail_seen_r && !src_is_wrc(cur_src);
    // no gating: with the watchdog RC off this trips, so software must drop the enable
    assign wfd_active = wfd_on;

    // below 1 kHz, timed on watchdog RC
    scf_miss_counter #(
        .LIMIT(scf_pkg::PRIMARY_FAIL_TICKS)
    ) u_primary_watch (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .enable_in(pfd_active),
        .tick_in(pin_rise[scf_pkg::PIN_WRC]),
        .seen_in(sel_edge),
        .fail_out(pfail_hit)
    );

    scf_miss_counter #(
        .LIMIT(WRC_FAIL_COUNT)
    ) u_wrc_watch (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .enable_in(wfd_active),
        .tick_in(sel_edge),
        .seen_in(pin_rise[scf_pkg::PIN_WRC]),
        .fail_out(wfail_hit)
    );

    assign fallback = pfail_hit && pfd_active && wrc_on && !src_is_wrc(cur_src);

    ////////////////////////////////////////////////////////////////////////////
    // control register update

    // failover is applied after a same-cycle write so the forced source wins
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        // detect enables taken on any stored write
        if (ctrl_commit)
        begin
            ctrl_nxt = bus_req_in.wdata;
            ctrl_nxt[scf_pkg::RSVD_BIT] = 1'b0;
        end
        if (fallback)
        begin
            ctrl_nxt[scf_pkg::SRC_LSB +: scf_pkg::SRC_W] = scf_pkg::SRC_WRC;
        end
    end

    // sticky failure flags; a write clears only the primary flag, and a new failure wins over that write
    always_comb
    begin
        pfail_seen_nxt = pfail_seen_r;
        wfail_seen_nxt = wfail_seen_r;
        if (ctrl_commit)
        begin
            pfail_seen_nxt = 1'b0;
        end
        if (fallback || (pfail_hit && pfd_active))
        begin
            pfail_seen_nxt = 1'b1;
        end
        if (wfail_hit)
        begin
            wfail_seen_nxt = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output next values

    wire logic [2:0] src_nxt;
    wire logic fast_nxt;
    wire logic pfail_evt_nxt;

    // outputs follow ctrl_nxt so pins and register never disagree for a cycle
    assign src_nxt = ctrl_nxt[scf_pkg::SRC_LSB +: scf_pkg::SRC_W];
    assign fast_nxt = (src_nxt != scf_pkg::SRC_PRC_SLOW);
    assign pfail_evt_nxt = pfail_hit && pfd_active;

    ////////////////////////////////////////////////////////////////////////////
    // read path

    logic [7:0] stat_word;

    // status bits sit at their package positions; unused bits read as zero
    always_comb
    begin
        stat_word = 8'h00;
        stat_word[scf_pkg::ST_UNLOCKED_BIT] = (lock_r == scf_pkg::LK_OPEN);
        stat_word[scf_pkg::ST_FIRST_BIT] = (lock_r == scf_pkg::LK_FIRST);
        stat_word[scf_pkg::ST_PFAIL_BIT] = pfail_seen_r;
        stat_word[scf_pkg::ST_WFAIL_BIT] = wfail_seen_r;
    end

    always_comb
    begin
        rdata_nxt = 8'h00;
        if (bus_req_in.rd && hit_ctrl)
        begin
            rdata_nxt = ctrl_r;
        end
        else if (bus_req_in.rd && hit_stat)
        begin
            rdata_nxt = stat_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state flops

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ctrl_r <= scf_pkg::CTRL_RESET;
            lock_r <= scf_pkg::LK_LOCKED;
            pfail_seen_r <= 1'b0;
            wfail_seen_r <= 1'b0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            lock_r <= lock_nxt;
            pfail_seen_r <= pfail_seen_nxt;
            wfail_seen_r <= wfail_seen_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            bus_rdata_out <= 8'h00;
            precision_rc_on_out <= scf_pkg::CTRL_RESET[scf_pkg::PRC_ON_BIT];
            precision_rc_fast_out <= 1'b1;
            watchdog_rc_on_out <= scf_pkg::CTRL_RESET[scf_pkg::WRC_ON_BIT];
            sys_clock_source_out <= scf_pkg::CTRL_RESET[scf_pkg::SRC_LSB +: scf_pkg::SRC_W];
            primary_fail_event_out <= 1'b0;
            watchdog_rc_fail_event_out <= 1'b0;
        end
        else
        begin
            bus_rdata_out <= rdata_nxt;
            precision_rc_on_out <= ctrl_nxt[scf_pkg::PRC_ON_BIT];
            precision_rc_fast_out <= fast_nxt;
            watchdog_rc_on_out <= ctrl_nxt[scf_pkg::WRC_ON_BIT];
            sys_clock_source_out <= src_nxt;
            primary_fail_event_out <= pfail_evt_nxt;
            watchdog_rc_fail_event_out <= wfail_hit;
        end
    end

endmodule : scf_clock_control

// >>> sim/scf_clock_control_assertions.sv
// checker: register unlock, read-back and failover relations at the top ports
`timescale 1ns/100ps
module scf_clock_control_assertions #(
    parameter int unsigned WRC_FAIL_COUNT = 8004
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // register port
    input wire scf_pkg::scf_bus_req_t bus_req_in,
    input wire logic [7:0] bus_rdata_out,
    // oscillator pins and controls
    input wire logic watchdog_rc_clk_in,
    input wire logic precision_rc_clk_in,
    input wire logic external_clock_pin_in,
    input wire logic precision_rc_on_out,
    input wire logic precision_rc_fast_out,
    input wire logic watchdog_rc_on_out,
    input wire logic [2:0] sys_clock_source_out,
    // events
    input wire logic primary_fail_event_out,
    input wire logic watchdog_rc_fail_event_out
);
    ////////////////////////////////////////////////////////////////////////////
    logic [1:0] lk_r;
    logic [1:0] lk_nxt;
    logic [1:0] det_r;
    logic wfail_r;
    wire ctl_wr = bus_req_in.wr && (bus_req_in.addr == scf_pkg::CTRL_ADDR);
    wire open_wr = ctl_wr && (lk_r == 2'd2);
    wire hit_e7 = bus_req_in.wdata == scf_pkg::UNLOCK_FIRST;
    wire hit_18 = bus_req_in.wdata == scf_pkg::UNLOCK_SECOND;
    assign lk_nxt = !ctl_wr ? lk_r : (lk_r == 2'd2) ? 2'd0 : hit_e7 ? 2'd1 : (lk_r == 2'd1 && hit_18) ? 2'd2 : 2'd0;
    // detect enables are not visible at the ports, so they are shadowed here
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            lk_r <= 2'd0;
            det_r <= 2'b00;
            wfail_r <= 1'b0;
        end
        else
        begin
            lk_r <= lk_nxt;
            det_r <= open_wr ? bus_req_in.wdata[4:3] : det_r;
            wfail_r <= wfail_r | watchdog_rc_fail_event_out;
        end
    end
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////////////////////
    chk_locked_wr_dropped:
    assert property (ctl_wr && lk_r != 2'd2 |=> $stable(precision_rc_on_out) && $stable(watchdog_rc_on_out))
        else $error("locked write changed an enable");
    chk_open_wr_stored:
    assert property (open_wr |=> precision_rc_on_out == $past(bus_req_in.wdata[7])
        && watchdog_rc_on_out == $past(bus_req_in.wdata[5])) else $error("unlocked write not stored");
    chk_src_stored:
    assert property (open_wr |=> sys_clock_source_out == $past(bus_req_in.wdata[2:0]) || primary_fail_event_out)
        else $error("source field not stored");
    chk_fast_mode:
    assert property (precision_rc_fast_out == (sys_clock_source_out != 3'b001)) else $error("fast mode wrong");
    chk_read_value:
    assert property (bus_req_in.rd && bus_req_in.addr == scf_pkg::CTRL_ADDR |=> bus_rdata_out ==
        {$past(precision_rc_on_out), 1'b0, $past(watchdog_rc_on_out), $past(det_r), $past(sys_clock_source_out)})
        else $error("control read-back wrong");
    chk_rdata_idle:
    assert property (!bus_req_in.rd |=> bus_rdata_out == 8'h00) else $error("read data without read");
    chk_failover_src:
    assert property (primary_fail_event_out |-> sys_clock_source_out == 3'b011) else $error("no fallback");
    chk_no_fallback:
    assert property (primary_fail_event_out |-> $past(watchdog_rc_on_out) && $past(sys_clock_source_out) != 3'b011)
        else $error("fallback when not allowed");
    chk_event_pulse:
    assert property (primary_fail_event_out |=> !primary_fail_event_out) else $error("primary event too long");
    chk_wfail_pulse:
    assert property (watchdog_rc_fail_event_out |=> !watchdog_rc_fail_event_out) else $error("wd event too long");
    chk_wfail_no_switch:
    assert property (watchdog_rc_fail_event_out && !primary_fail_event_out && !$past(open_wr)
        |-> $stable(sys_clock_source_out)) else $error("wd failure moved source");
    chk_no_primary_after:
    assert property (wfail_r |-> !primary_fail_event_out) else $error("primary event after wd failure");
    chk_prc_kept_on:
    assert property (precision_rc_on_out && !open_wr |=> precision_rc_on_out) else $error("rc switched off");
endmodule : scf_clock_control_assertions

// >>> sim/scf_clock_control_tb_top.sv
// testbench: unlock sequence, register access and clock failover scenarios
`timescale 1ns/100ps
module scf_clock_control_tb_top;
    localparam int unsigned FAIL_N = 20;
    localparam logic [11:0] CA = scf_pkg::CTRL_ADDR;
    logic core_clk_in;
    logic rst_in;
    scf_pkg::scf_bus_req_t bus_req;
    logic [7:0] rdata;
    logic wrc_pin = 1'b0;
    logic prc_pin = 1'b0;
    logic ext_pin = 1'b0;
    logic prc_on;
    logic prc_fast;
    logic wrc_on;
    logic [2:0] src;
    logic pfail;
    logic wfail;
    logic wrc_run;
    logic prc_run;
    logic [7:0] rv;
    logic [7:0] d;
    int err_total = 0;
    int n_tests = 0;
    int n_pfail = 0;
    int n_wfail = 0;
    int unsigned tk = 0;
    int cyc;
    logic [2:0] codes [4] = '{3'b000, 3'b001, 3'b011, 3'b100};

    scf_clock_control #(.WRC_FAIL_COUNT(FAIL_N)) dut_u (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .bus_req_in(bus_req), .bus_rdata_out(rdata),
        .watchdog_rc_clk_in(wrc_pin), .precision_rc_clk_in(prc_pin), .external_clock_pin_in(ext_pin),
        .precision_rc_on_out(prc_on), .precision_rc_fast_out(prc_fast), .watchdog_rc_on_out(wrc_on),
        .sys_clock_source_out(src), .primary_fail_event_out(pfail), .watchdog_rc_fail_event_out(wfail));

    initial
    begin
        core_clk_in = 1'b0;
        forever #20 core_clk_in = ~core_clk_in;
    end
    ////////////////////////////////////////////////////////////////////////////
    // slow oscillator pins: rc every 4 cycles, watchdog every 16
    always @(posedge core_clk_in)
    begin
        tk <= tk + 1;
        if (prc_run && tk[0])
            prc_pin <= ~prc_pin;
        if (prc_run && tk[0])
            ext_pin <= ~ext_pin;
        if (wrc_run && tk[2:0] == 3'd0)
            wrc_pin <= ~wrc_pin;
        if (pfail === 1'b1)
            n_pfail <= n_pfail + 1;
        if (wfail === 1'b1)
            n_wfail <= n_wfail + 1;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check
    task automatic bus_wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge core_clk_in);
        bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk_in);
        bus_req.wr <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [11:0] a, output logic [7:0] v);
        @(posedge core_clk_in);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk_in);
        bus_req.rd <= 1'b0;
        #1;
        v = rdata;
    endtask : bus_rd
    function automatic logic [7:0] exp_outs(input logic [7:0] e);
        return {e[7], 1'b0, e[5], e[2:0] != 3'b001, 1'b0, e[2:0]};
    endfunction : exp_outs
    task automatic verify(input logic [7:0] e);
        bus_rd(CA, rv);
        check("ctrl", rv, e);
        check("outs", {prc_on, 1'b0, wrc_on, prc_fast, 1'b0, src}, exp_outs(e));
    endtask : verify
    task automatic ctrl_set(input logic [7:0] v);
        bus_wr(CA, scf_pkg::UNLOCK_FIRST);
        bus_wr(CA, scf_pkg::UNLOCK_SECOND);
        bus_wr(CA, v);
    endtask : ctrl_set
    task automatic wait_pf(input int lim);
        for (cyc = 0; cyc < lim && n_pfail == 0; cyc++)
            @(posedge core_clk_in);
    endtask : wait_pf
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge core_clk_in);
        err_total++;
        give_verdict();
    end
    initial
    begin
        void'($urandom(32'h7d00a4ad));
        rst_in = 1'b1;
        bus_req = '0;
        {wrc_run, prc_run} = 2'b00;
        repeat (10) @(posedge core_clk_in);
        rst_in <= 1'b0;
        verify(scf_pkg::CTRL_RESET);
        // wrong orders leave the register alone
        bus_wr(CA, 8'h55);
        bus_wr(CA, 8'h18);
        bus_wr(CA, 8'he7);
        bus_wr(CA, 8'h3c);
        verify(8'ha0);
        // unlock with reads and foreign accesses in between
        bus_wr(CA, 8'he7);
        bus_rd(CA, rv);
        check("rd_mid", rv, 8'ha0);
        bus_rd(scf_pkg::STAT_ADDR, rv);
        check("stat_first", rv, 8'h01 << scf_pkg::ST_FIRST_BIT);
        bus_wr(12'h0f80, 8'h18);
        bus_rd(12'h0f90, rv);
        check("unmapped", rv, 8'h00);
        bus_wr(CA, 8'h18);
        bus_rd(CA, rv);
        check("rd_open", rv, 8'ha0);
        bus_rd(scf_pkg::STAT_ADDR, rv);
        check("stat_open", rv, 8'h01 << scf_pkg::ST_UNLOCKED_BIT);
        bus_wr(CA, 8'hc1);
        verify(8'h81);
        bus_wr(CA, 8'ha0);
        verify(8'h81);
        // every source code, random enables, detectors kept off
        for (int i = 0; i < 8; i++)
        begin
            d = 8'($urandom);
            // pin clock never runs with primary detect on
            d[4:0] = {2'b00, codes[i % 4]};
            d[7] = d[7] | ~d[5];
            ctrl_set(d);
            verify(d & 8'hbf);
        end
        ctrl_set(8'ha4);
        verify(8'ha4);
        // primary failover: enables set after the select write
        wrc_run <= 1'b1;
        prc_run <= 1'b1;
        // select written with detectors off, enable set afterwards
        ctrl_set(8'ha0);
        ctrl_set(8'hb0);
        wait_pf(300);
        check("pf_early", 8'(n_pfail), 8'd0);
        prc_run <= 1'b0;
        wait_pf(400);
        check("pf_time", 8'(cyc >= 144 && cyc <= 172), 8'd1);
        repeat (2) @(posedge core_clk_in);
        check("pf_count", 8'(n_pfail), 8'd1);
        check("pf_src", {5'h0, src}, 8'h03);
        check("pf_prc_on", {7'h0, prc_on}, 8'h01);
        bus_rd(scf_pkg::STAT_ADDR, rv);
        check("pf_stat", rv, 8'h01 << scf_pkg::ST_PFAIL_BIT);
        repeat (300) @(posedge core_clk_in);
        check("pf_again", 8'(n_pfail), 8'd1);
        // watchdog rc off: no recovery path, no event
        ctrl_set(8'ha3);
        // watchdog detect kept off while the watchdog RC is off
        ctrl_set(8'h80);
        ctrl_set(8'h90);
        repeat (300) @(posedge core_clk_in);
        check("pf_wrc_off", 8'(n_pfail), 8'd1);
        // watchdog rc failure counted in selected-source ticks
        wrc_run <= 1'b0;
        prc_run <= 1'b1;
        ctrl_set(8'ha0);
        ctrl_set(8'ha8);
        for (cyc = 0; cyc < 300 && n_wfail == 0; cyc++)
            @(posedge core_clk_in);
        check("wf_time", 8'(cyc >= FAIL_N * 4 - 4 && cyc <= FAIL_N * 4 + 12), 8'd1);
        check("wf_src", {5'h0, src}, 8'h00);
        bus_rd(scf_pkg::STAT_ADDR, rv);
        check("wf_stat", rv, 8'h01 << scf_pkg::ST_WFAIL_BIT);
        // primary detection is dead after a watchdog failure
        ctrl_set(8'ha0);
        ctrl_set(8'hb0);
        wrc_run <= 1'b1;
        prc_run <= 1'b0;
        repeat (300) @(posedge core_clk_in);
        check("pf_dead", 8'(n_pfail), 8'd1);
        check("wf_count", 8'(n_wfail), 8'd1);
        give_verdict();
    end
endmodule : scf_clock_control_tb_top

bind scf_clock_control scf_clock_control_assertions #(.WRC_FAIL_COUNT(WRC_FAIL_COUNT)) chk_u (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .bus_req_in(bus_req_in), .bus_rdata_out(bus_rdata_out),
    .watchdog_rc_clk_in(watchdog_rc_clk_in), .precision_rc_clk_in(precision_rc_clk_in),
    .external_clock_pin_in(external_clock_pin_in), .precision_rc_on_out(precision_rc_on_out),
    .precision_rc_fast_out(precision_rc_fast_out), .watchdog_rc_on_out(watchdog_rc_on_out),
    .sys_clock_source_out(sys_clock_source_out), .primary_fail_event_out(primary_fail_event_out),
    .watchdog_rc_fail_event_out(watchdog_rc_fail_event_out));
